// *** src/rcc_pkg.sv ***
`default_nettype none
package rcc_pkg;
    localparam int ADR_W = 4;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int REG_W = 16;

    // byte offsets on the bus
    localparam logic [ADR_W-1:0] OFS_CAUSE = 4'h0;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 4'h8;

    // field positions of reset_cause_control
    localparam int BIT_TRAP = 15;
    localparam int BIT_ILLOP = 14;
    localparam int BIT_FLASH_KEEP = 11;
    localparam int BIT_CFG_MISM = 9;
    localparam int BIT_CORE_KEEP = 8;
    localparam int BIT_PIN_RST = 7;
    localparam int BIT_SOFT_RST = 6;
    localparam int BIT_SOFT_WDT = 5;
    localparam int BIT_WDT_TO = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BROWNOUT = 1;
    localparam int BIT_POWERON = 0;

    localparam logic [REG_W-1:0] CAUSE_IMPL_MASK = 16'hcbff;
    localparam logic [REG_W-1:0] CAUSE_FLAG_MASK = 16'hc2df;
    localparam logic [REG_W-1:0] CAUSE_RESET = 16'h0003;
    localparam logic [REG_W-1:0] IRQ_RESET = 16'h0000;

    typedef enum logic [0:0] {
        RCC_BUS_IDLE = 1'b0,
        RCC_BUS_ACK = 1'b1
    } rcc_bus_st_t;
endpackage
`default_nettype wire

// *** src/rcc_sticky.sv ***
`default_nettype none
module rcc_sticky #(
    parameter int W = 16,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,          // system clock
    input wire logic rst_i,          // sync reset, active high
    input wire logic [W-1:0] set_i,  // hardware set pulses
    input wire logic [W-1:0] clr_i,  // write-one-to-clear mask
    output logic [W-1:0] q_o         // sticky bits
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // set is applied last so an event in the clear cycle survives
    always_comb begin
        q_nxt = (q_r & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule
`default_nettype wire

// *** src/rcc_reset_cause.sv ***
// Overview of operation
// (R1) a trap conflict reset sets the trap flag, bit 15; otherwise it stays clear
// (R2) illegal opcode, bad address mode or uninitialised pointer reset sets bit 14
// (R3) bit 11 one keeps the flash regulator on in sleep; zero puts it to standby
// (R4) a configuration mismatch reset sets bit 9
// (R5) bit 8 zero puts the main regulator to standby in sleep; one keeps it on
// (R6) a master clear pin reset sets bit 7
// (R7) a software reset instruction sets bit 6
// (R8) bit 5 is the software watchdog enable: one runs it, zero stops it
// (R9) a watchdog timeout sets bit 4; otherwise it stays clear
// (R10) software may set or clear any flag; that never causes a reset
// (R11) fuse enable at one runs the watchdog always, ignoring bit 5
// (R12) power-on gives bits 1 and 0 one, others zero; 13, 12, 10 read zero
// (R13) wake from sleep or idle, brown-out and power-on set their flags
//
// Register access over Wishbone and the address map are this design's own decisions.
`default_nettype none
module rcc_reset_cause (
    input wire logic clk_i,                                  // 50 MHz system clock
    input wire logic rst_i,                                  // power-on reset, sync, high
    input wire logic wb_cyc_i,                               // bus cycle
    input wire logic wb_stb_i,                               // bus strobe
    input wire logic wb_we_i,                                // write enable
    input wire logic [rcc_pkg::ADR_W-1:0] wb_adr_i,          // byte address
    input wire logic [rcc_pkg::DAT_W-1:0] wb_dat_i,          // write data
    input wire logic [rcc_pkg::SEL_W-1:0] wb_sel_i,          // byte selects
    output logic [rcc_pkg::DAT_W-1:0] wb_dat_o,              // read data
    output logic wb_ack_o,                                   // acknowledge
    input wire logic trap_conflict_i,                        // trap conflict reset pulse
    input wire logic illegal_op_i,                           // illegal op reset pulse
    input wire logic config_mismatch_i,                      // config mismatch reset pulse
    input wire logic master_clear_pin_i,                     // pin reset pulse
    input wire logic soft_reset_i,                           // reset instruction pulse
    input wire logic watchdog_timeout_i,                     // watchdog time-out pulse
    input wire logic sleep_wake_i,                           // woke from sleep pulse
    input wire logic idle_wake_i,                            // woke from idle pulse
    input wire logic brownout_i,                             // brown-out reset pulse
    input wire logic watchdog_fuse_enable_i,                 // fuse bit, 1 = unprogrammed
    input wire logic sleeping_i,                             // device is in sleep
    output logic watchdog_run_o,                             // watchdog enabled
    output logic flash_reg_standby_o,                        // flash regulator in standby
    output logic core_reg_standby_o,                         // main regulator in standby
    output logic [rcc_pkg::REG_W-1:0] reset_cause_control_o, // register contents
    output logic irq_o                                       // level interrupt
);
    import rcc_pkg::*;

    rcc_bus_st_t bus_st_r;
    rcc_bus_st_t bus_st_nxt;
    logic [DAT_W-1:0] rdat_r;
    logic [DAT_W-1:0] rdat_nxt;
    logic [REG_W-1:0] cause_r;
    logic [REG_W-1:0] cause_nxt;
    logic [REG_W-1:0] mask_r;
    logic [REG_W-1:0] mask_nxt;
    logic [REG_W-1:0] irq_stat;
    logic [REG_W-1:0] irq_clr;
    logic [REG_W-1:0] hw_ev;
    logic wdt_run_r;
    logic wdt_run_nxt;
    logic flash_sb_r;
    logic flash_sb_nxt;
    logic core_sb_r;
    logic core_sb_nxt;
    logic req;
    logic wr_commit;
    logic wr_cause;
    logic wr_stat;
    logic wr_mask;

    // byte-lane merge of a 16-bit register from a 32-bit write
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0] old_v,
        input logic [DAT_W-1:0] new_v,
        input logic [SEL_W-1:0] sel
    );
        logic [REG_W-1:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // bus slave: one wait cycle, ack for exactly one cycle
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_commit = (bus_st_r == RCC_BUS_ACK) && req && wb_we_i;
    assign wr_cause = wr_commit && (wb_adr_i == OFS_CAUSE);
    assign wr_stat = wr_commit && (wb_adr_i == OFS_IRQ_STAT);
    assign wr_mask = wr_commit && (wb_adr_i == OFS_IRQ_MASK);

    always_comb begin
        bus_st_nxt = bus_st_r;
        rdat_nxt = rdat_r;
        case (bus_st_r)
            RCC_BUS_IDLE: begin
                if (req) begin
                    bus_st_nxt = RCC_BUS_ACK;
                    // unmapped offsets read as zero and ignore writes
                    case (wb_adr_i)
                        OFS_CAUSE: rdat_nxt = {16'h0000, cause_r};
                        OFS_IRQ_STAT: rdat_nxt = {16'h0000, irq_stat};
                        OFS_IRQ_MASK: rdat_nxt = {16'h0000, mask_r};
                        default: rdat_nxt = 32'h0000_0000;
                    endcase
                end
            end
            RCC_BUS_ACK: begin
                bus_st_nxt = RCC_BUS_IDLE;
            end
            default: begin
                bus_st_nxt = RCC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st_r <= RCC_BUS_IDLE;
            rdat_r <= 32'h0000_0000;
        end else begin
            bus_st_r <= bus_st_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = (bus_st_r == RCC_BUS_ACK);
    assign wb_dat_o = rdat_r;

    // hardware cause events, placed at their register positions
    always_comb begin
        hw_ev = 16'h0000;
        hw_ev[BIT_TRAP] = trap_conflict_i;           // R1
        hw_ev[BIT_ILLOP] = illegal_op_i;             // R2
        hw_ev[BIT_CFG_MISM] = config_mismatch_i;     // R4
        hw_ev[BIT_PIN_RST] = master_clear_pin_i;     // R6
        hw_ev[BIT_SOFT_RST] = soft_reset_i;          // R7
        hw_ev[BIT_WDT_TO] = watchdog_timeout_i;      // R9
        hw_ev[BIT_SLEEP] = sleep_wake_i;             // R13
        hw_ev[BIT_IDLE] = idle_wake_i;               // R13
        hw_ev[BIT_BROWNOUT] = brownout_i;            // R13
    end

    // cause register: software write first, hardware set wins over it
    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = merge16(cause_r, wb_dat_i, wb_sel_i); // R8 R10
        end
        cause_nxt = (cause_nxt | (hw_ev & CAUSE_FLAG_MASK)) & CAUSE_IMPL_MASK; // R12
    end

    // only power-on reloads this register, to CAUSE_RESET with bits 1 and 0 set; the other resets only flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_r <= CAUSE_RESET; // R12
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // interrupt status and mask share the cause layout
    assign irq_clr = wr_stat ? merge16(16'h0000, wb_dat_i, wb_sel_i) : 16'h0000;

    rcc_sticky #(
        .W(REG_W),
        .RST_VAL(IRQ_RESET)
    ) u_irq_stat (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(hw_ev & CAUSE_FLAG_MASK),
        .clr_i(irq_clr),
        .q_o(irq_stat)
    );

    always_comb begin
        mask_nxt = mask_r;
        if (wr_mask) begin
            mask_nxt = merge16(mask_r, wb_dat_i, wb_sel_i) & CAUSE_FLAG_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= IRQ_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    assign irq_o = |(irq_stat & mask_r);

    // watchdog enable and regulator standby, registered outputs
    always_comb begin
        wdt_run_nxt = watchdog_fuse_enable_i || cause_r[BIT_SOFT_WDT]; // R8 R11
        flash_sb_nxt = sleeping_i && !cause_r[BIT_FLASH_KEEP];        // R3
        core_sb_nxt = sleeping_i && !cause_r[BIT_CORE_KEEP];          // R5
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_run_r <= 1'b0;
            flash_sb_r <= 1'b0;
            core_sb_r <= 1'b0;
        end else begin
            wdt_run_r <= wdt_run_nxt;
            flash_sb_r <= flash_sb_nxt;
            core_sb_r <= core_sb_nxt;
        end
    end

    // no reset request output exists, so a software set cannot reset
    assign watchdog_run_o = wdt_run_r;
    assign flash_reg_standby_o = flash_sb_r;
    assign core_reg_standby_o = core_sb_r;
    assign reset_cause_control_o = cause_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req_idle;
        req && (bus_st_r == RCC_BUS_IDLE);
    endsequence

    sequence s_one_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_bus_ack;
        s_req_idle |=> s_one_ack;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("ack not a single cycle");

    property p_trap;
        trap_conflict_i |=> cause_r[BIT_TRAP];
    endproperty
    a_trap: assert property (p_trap) else $error("trap flag not set"); // R1

    property p_illop;
        illegal_op_i |=> cause_r[BIT_ILLOP];
    endproperty
    a_illop: assert property (p_illop) else $error("illegal op flag not set"); // R2

    property p_flash_sb;
        (sleeping_i && !cause_r[BIT_FLASH_KEEP]) |=> flash_reg_standby_o;
    endproperty
    a_flash_sb: assert property (p_flash_sb) else $error("flash regulator awake"); // R3

    property p_cfg;
        config_mismatch_i |=> cause_r[BIT_CFG_MISM];
    endproperty
    a_cfg: assert property (p_cfg) else $error("mismatch flag not set"); // R4

    property p_core_sb;
        (sleeping_i && cause_r[BIT_CORE_KEEP]) |=> !core_reg_standby_o;
    endproperty
    a_core_sb: assert property (p_core_sb) else $error("main regulator in standby"); // R5

    property p_pin;
        master_clear_pin_i |=> cause_r[BIT_PIN_RST];
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset flag not set"); // R6

    property p_soft;
        soft_reset_i |=> cause_r[BIT_SOFT_RST];
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset flag not set"); // R7

    property p_wdt_en;
        (wr_cause && wb_sel_i[0] && !watchdog_fuse_enable_i)
            |=> (cause_r[BIT_SOFT_WDT] == $past(wb_dat_i[BIT_SOFT_WDT]))
            ##1 (watchdog_run_o == $past(cause_r[BIT_SOFT_WDT]));
    endproperty
    a_wdt_en: assert property (p_wdt_en) else $error("watchdog enable wrong"); // R8

    property p_watchdog_timeout_flag;
        watchdog_timeout_i |=> cause_r[BIT_WDT_TO];
    endproperty
    a_watchdog_timeout_flag: assert property (p_watchdog_timeout_flag) else $error("time-out flag not set"); // R9

    property p_sw_write;
        (wr_cause && (wb_sel_i[1:0] == 2'h3) && (hw_ev == 16'h0000))
            |=> (cause_r == ($past(wb_dat_i[15:0]) & CAUSE_IMPL_MASK));
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("software write lost"); // R10

    property p_fuse;
        watchdog_fuse_enable_i |=> watchdog_run_o;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse did not force watchdog"); // R11

    property p_unimpl;
        (cause_r & ~CAUSE_IMPL_MASK) == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // R12

    property p_wake;
        (sleep_wake_i || idle_wake_i)
            |=> (cause_r[BIT_SLEEP] || !$past(sleep_wake_i))
            && (cause_r[BIT_IDLE] || !$past(idle_wake_i));
    endproperty
    a_wake: assert property (p_wake) else $error("wake flag not set"); // R13

    // an unmasked event must reach the pin through status and mask
    property p_irq;
        ((|(hw_ev & mask_r)) && !wr_mask) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule
`default_nettype wire

// *** tb/tb_reset_cause_control.sv ***
`default_nettype none
module tb_reset_cause_control;
    timeunit 1ns;
    timeprecision 1ps;
    import rcc_pkg::*;
    localparam int EV_BIT [9] = '{BIT_TRAP, BIT_ILLOP, BIT_CFG_MISM, BIT_PIN_RST,
        BIT_SOFT_RST, BIT_WDT_TO, BIT_SLEEP, BIT_IDLE, BIT_BROWNOUT};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic fuse = 1'b0;
    logic slp = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [DAT_W-1:0] wdat = '0;
    logic [SEL_W-1:0] sel = '0;
    logic [8:0] ev = '0;
    logic [DAT_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic watchdog_run_o;
    logic flash_reg_standby_o;
    logic core_reg_standby_o;
    logic [REG_W-1:0] reset_cause_control_o;
    logic irq_o;
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'h643a;

    rcc_reset_cause DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .trap_conflict_i(ev[0]), .illegal_op_i(ev[1]),
        .config_mismatch_i(ev[2]), .master_clear_pin_i(ev[3]), .soft_reset_i(ev[4]),
        .watchdog_timeout_i(ev[5]), .sleep_wake_i(ev[6]), .idle_wake_i(ev[7]),
        .brownout_i(ev[8]), .watchdog_fuse_enable_i(fuse), .sleeping_i(slp),
        .watchdog_run_o(watchdog_run_o), .flash_reg_standby_o(flash_reg_standby_o),
        .core_reg_standby_o(core_reg_standby_o),
        .reset_cause_control_o(reset_cause_control_o), .irq_o(irq_o)
    );

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // entered right after a rising edge; returns one idle edge after the ack
    task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [15:0] d,
        input logic [SEL_W-1:0] s, output logic [DAT_W-1:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        sel <= s;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                tally_and_finish();
            end
            @(posedge clk_i);
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [ADR_W-1:0] a, input logic [15:0] d);
        logic [DAT_W-1:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, output logic [DAT_W-1:0] q);
        bus(1'b0, a, 16'h0000, 4'hf, q);
    endtask

    // expected {watchdog run, flash standby, core standby}
    function automatic logic [2:0] exp_pwr(input logic f, input logic s,
        input logic [15:0] v);
        return {f | v[BIT_SOFT_WDT], s & ~v[BIT_FLASH_KEEP], s & ~v[BIT_CORE_KEEP]};
    endfunction

    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        logic [DAT_W-1:0] q;
        logic [15:0] v;
        logic [15:0] exp_c;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CAUSE, q);
        check(q, {16'h0000, CAUSE_RESET});
        check({16'h0000, reset_cause_control_o}, {16'h0000, CAUSE_RESET});
        rd(OFS_IRQ_STAT, q);
        check(q, 32'h0000_0000);
        rd(OFS_IRQ_MASK, q);
        check(q, 32'h0000_0000);
        wr(4'hc, 16'hffff);
        rd(4'hc, q);
        check(q, 32'h0000_0000);
        rd(OFS_CAUSE, q);
        check(q, {16'h0000, CAUSE_RESET});
        $display("test reset values done");

        wr(OFS_CAUSE, 16'h0000);
        exp_c = 16'h0000;
        for (int i = 0; i < 9; i++) begin
            ev[i] <= 1'b1;
            @(posedge clk_i);
            ev <= '0;
            @(posedge clk_i);
            exp_c = exp_c | (16'h0001 << EV_BIT[i]);
            rd(OFS_CAUSE, q);
            check(q, {16'h0000, exp_c});
            rd(OFS_IRQ_STAT, q);
            check(q, {16'h0000, exp_c});
        end
        check({31'h0, irq_o}, 32'h0);
        wr(OFS_IRQ_MASK, 16'hffff);
        rd(OFS_IRQ_MASK, q);
        check(q, {16'h0000, CAUSE_FLAG_MASK});
        check({31'h0, irq_o}, 32'h1);
        wr(OFS_IRQ_STAT, 16'hffff);
        rd(OFS_IRQ_STAT, q);
        check(q, 32'h0000_0000);
        check({31'h0, irq_o}, 32'h0);
        ev[0] <= 1'b1;
        @(posedge clk_i);
        ev <= '0;
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(OFS_IRQ_STAT, 16'h8000);
        check({31'h0, irq_o}, 32'h0);
        rd(OFS_CAUSE, q);
        check(q, {16'h0000, exp_c});
        $display("test event flags done");

        // corner values first, then random words and levels
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : 16'($random(seed));
            fuse <= (k < 2) ? 1'b0 : 1'($random(seed));
            slp <= (k == 1) ? 1'b0 : 1'($random(seed));
            wr(OFS_CAUSE, v);
            rd(OFS_CAUSE, q);
            check(q, {16'h0000, v & CAUSE_IMPL_MASK});
            repeat (2) @(posedge clk_i);
            check({29'h0, watchdog_run_o, flash_reg_standby_o, core_reg_standby_o},
                {29'h0, exp_pwr(fuse, slp, v)});
        end
        wr(OFS_CAUSE, 16'h0000);
        bus(1'b1, OFS_CAUSE, 16'hffff, 4'h1, q);
        rd(OFS_CAUSE, q);
        check(q, 32'h0000_00ff);
        $display("test software access done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
